// *** dv/csc_controller_props.sv ***
// Checker for the synthesizer configuration controller
`timescale 1ns/100ps
module csc_controller_chk (
	input wire i_sys_clk,              // Clock
	input wire i_nrst,                 // Reset
	input wire i_config_trigger,       // Start
	input wire o_sda,                  // Data drive value
	input wire o_sda_oe,               // Data drive enable
	input wire o_scl,                  // Serial clock
	input wire o_config_complete_flag, // Done
	input wire o_nack_err              // Missing acknowledge
);
	reg        scl_q_r;
	reg [15:0] scl_len_r;
	// Cycles the serial clock has held its level
	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			scl_q_r   <= 1'b1;
			scl_len_r <= 16'h0000;
		end else begin
			scl_q_r <= o_scl;
			if (o_scl != scl_q_r) scl_len_r <= 16'h0000;
			else if (scl_len_r != 16'hFFFF) scl_len_r <= scl_len_r + 16'h0001;
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_trig_rise;
		!i_config_trigger ##1 i_config_trigger;
	endsequence
	sequence s_pass_begin;
		##[1:6] !o_config_complete_flag;
	endsequence
	a_reset_idle_lines: assert property ($rose(i_nrst) |-> o_scl && !o_sda_oe
		&& !o_config_complete_flag && !o_nack_err) else $error("bad state after reset");
	a_flag_falls_start: assert property (o_config_complete_flag ##0 s_trig_rise
		|-> s_pass_begin) else $error("start edge not taken");
	a_no_level_restart: assert property ((o_config_complete_flag && i_config_trigger)[*6]
		|=> o_config_complete_flag) else $error("level restarted pass");
	a_pass_flag_low: assert property ((o_sda_oe || !o_scl) |-> !o_config_complete_flag)
		else $error("done high during bus activity");
	a_done_bus_idle: assert property ($rose(o_config_complete_flag) |-> o_scl && !o_sda_oe)
		else $error("done before bus idle");
	a_sda_drive_zero: assert property (!o_sda) else $error("data drive not low");
	a_scl_phase_len: assert property ((o_scl != scl_q_r) |-> scl_len_r >= 16'h007C)
		else $error("serial clock phase too short");
	a_nack_cleared: assert property ($fell(o_config_complete_flag) |-> ##[0:2] !o_nack_err)
		else $error("error flag not cleared");
endmodule
bind csc_controller csc_controller_chk u_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
	.i_config_trigger(i_config_trigger), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_scl(o_scl),
	.o_config_complete_flag(o_config_complete_flag), .o_nack_err(o_nack_err));

// *** dv/csc_synth_model.sv ***
// Synthesizer model: acknowledges every byte and logs it
`timescale 1ns/100ps
module csc_synth_model (
	input  wire i_scl,      // Serial clock
	input  wire i_sda,      // Resolved data line
	output reg  o_pull_low  // Drives data low
);
	reg [7:0] mem [0:23];
	reg [7:0] sh;
	integer   nb;
	integer   bc;
	initial begin
		o_pull_low = 1'b0;
		nb = 0;
		bc = 0;
	end
	always @(negedge i_sda) if (i_scl) bc = 0;
	always @(posedge i_scl) begin
		if (bc < 8) begin
			sh = {sh[6:0], i_sda};
			bc = bc + 1;
			if (bc == 8) begin
				mem[nb] = sh;
				nb = nb + 1;
			end
		end else bc = 9;
	end
	// Acknowledge slot: pull low from the clock fall after the eighth bit until the next fall
	always @(negedge i_scl) begin
		if (bc == 8) o_pull_low <= 1'b1;
		else if (bc == 9) begin
			o_pull_low <= 1'b0;
			bc = 0;
		end
	end
endmodule

// *** dv/tb.sv ***
// Testbench: both variants program a synthesizer model at once
`timescale 1ns/100ps
module tb;
	reg        clk, nrst, trig;
	reg  [2:0] sa, sb, sc, sd;
	reg  [3:0] msel;
	wire       oe0, oe1, scl0, scl1, pl0, pl1, dn0, dn1, nk0, nk1;
	wire       sda0 = ~(oe0 | pl0);
	wire       sda1 = ~(oe1 | pl1);
	integer    mismatches, checks, i;
	csc_controller #(.MEM_VARIANT(0)) uut (.i_sys_clk(clk), .i_nrst(nrst),
		.i_config_trigger(trig), .i_chan_freq_select_a(sa), .i_chan_freq_select_b(sb),
		.i_chan_freq_select_c(sc), .i_chan_freq_select_d(sd), .i_mem_freq_select(msel),
		.i_sda(sda0), .o_sda(), .o_sda_oe(oe0), .o_scl(scl0), .o_config_complete_flag(dn0),
		.o_nack_err(nk0));
	csc_controller #(.MEM_VARIANT(1)) uut_mem (.i_sys_clk(clk), .i_nrst(nrst),
		.i_config_trigger(trig), .i_chan_freq_select_a(sa), .i_chan_freq_select_b(sb),
		.i_chan_freq_select_c(sc), .i_chan_freq_select_d(sd), .i_mem_freq_select(msel),
		.i_sda(sda1), .o_sda(), .o_sda_oe(oe1), .o_scl(scl1), .o_config_complete_flag(dn1),
		.o_nack_err(nk1));
	csc_synth_model m0 (.i_scl(scl0), .i_sda(sda0), .o_pull_low(pl0));
	csc_synth_model m1 (.i_scl(scl1), .i_sda(sda1), .o_pull_low(pl1));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task check(input [7:0] seen, input [7:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("Checks %0d mismatches %0d", checks, mismatches);
			if (mismatches == 0 && checks > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	function [7:0] exp_byte(input mv, input integer n);
		integer e, k;
		reg [2:0] s;
		begin
			e = n / 3;
			k = n % 3;
			s = ({sd, sc, sb, sa} >> (3 * e));
			if (k == 0) exp_byte = 8'hEE;
			else if (e == (mv ? 6 : 4)) exp_byte = (k == 1) ? 8'h1C : 8'h01;
			else if (k == 1) exp_byte = 8'h10 + e[7:0];
			else if (mv) exp_byte = 8'h92;
			else exp_byte = (s == 3'h0) ? 8'h00 : 8'h80 + {5'h00, s};
		end
	endfunction
	initial begin
		nrst = 1'b0; trig = 1'b1; msel = 4'h2; mismatches = 0; checks = 0;
		sa = 3'h1; sb = 3'h7; sc = 3'h0; sd = 3'h5;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		check({4'h0, dn0, oe0, nk0, scl0}, 8'h01);
		repeat (400) @(negedge clk);
		check({4'h0, oe0, oe1, scl0, scl1}, 8'h03);
		check(m0.nb[7:0], 8'h00);
		$display("Reset test done");
		trig = 1'b0;
		@(negedge clk) trig = 1'b1;
		repeat (10) @(negedge clk);
		check({6'h00, dn0, dn1}, 8'h00);
		trig = 1'b0;
		@(negedge clk) trig = 1'b1;
		for (i = 0; i < 80000 && dn0 !== 1'b1; i = i + 1) @(negedge clk);
		check({7'h00, dn0}, 8'h01);
		check({7'h00, nk0}, 8'h00);
		check(m0.nb[7:0], 8'h0F);
		for (i = 0; i < 15; i = i + 1) check(m0.mem[i], exp_byte(1'b0, i));
		$display("Four-channel pass test done");
		sa = 3'h6;
		sb = 3'h2;
		trig = 1'b0;
		@(negedge clk) trig = 1'b1;
		repeat (10) @(negedge clk);
		check({6'h00, dn0, dn1}, 8'h00);
		for (i = 0; i < 40000 && dn1 !== 1'b1; i = i + 1) @(negedge clk);
		check({6'h00, dn1, nk1}, 8'h02);
		check(m1.nb[7:0], 8'h15);
		for (i = 0; i < 21; i = i + 1) check(m1.mem[i], exp_byte(1'b1, i));
		check(m0.mem[17], exp_byte(1'b0, 2));
		check(m0.mem[20], exp_byte(1'b0, 5));
		repeat (300) @(negedge clk);
		check({6'h00, dn1, scl1}, 8'h03);
		$display("Retrigger test done");
		conclude;
	end
	initial begin
		#2300000;
		mismatches = mismatches + 1;
		conclude;
	end
endmodule

// *** hdl/csc_controller.v ***
// Clock synthesizer configuration controller, I2C master
`timescale 1ns/100ps
`include "csc_defines.vh"

module csc_controller #(
	parameter MEM_VARIANT = 0                  // 0: four 3-bit selects, 1: one 4-bit select
) (
	input  wire       i_sys_clk,               // 50 MHz system clock
	input  wire       i_nrst,                  // Synchronous reset, active low
	input  wire       i_config_trigger,        // Start, rising edge
	input  wire [2:0] i_chan_freq_select_a,    // Port A frequency select
	input  wire [2:0] i_chan_freq_select_b,    // Port B frequency select
	input  wire [2:0] i_chan_freq_select_c,    // Port C frequency select
	input  wire [2:0] i_chan_freq_select_d,    // Port D frequency select
	input  wire [3:0] i_mem_freq_select,       // Memory clock select
	input  wire       i_sda,                   // Serial data line level
	output reg        o_sda,                   // Serial data drive value
	output reg        o_sda_oe,                // Serial data drive enable
	output reg        o_scl,                   // Serial clock
	output reg        o_config_complete_flag,  // Configuration complete
	output reg        o_nack_err               // Missing acknowledge in last pass
);

	//--------------------------------------------------------------
	// States and constants
	//--------------------------------------------------------------
	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_START = 3'd1;
	localparam [2:0] ST_BIT   = 3'd2;
	localparam [2:0] ST_STOP  = 3'd3;
	localparam integer QTR_CYC  = `CSC_I2C_QTR_CYC;
	localparam [6:0] QTR_LAST = QTR_CYC[6:0] - 7'h01;
	localparam [2:0] LAST_ENT = MEM_VARIANT ? `CSC_ENTRIES_MEM : `CSC_ENTRIES_QSFP;

	reg [2:0]  state_r;
	reg [6:0]  tick_cnt_r;
	reg [1:0]  phase_r;
	reg [4:0]  bit_idx_r;
	reg [2:0]  entry_r;
	reg [26:0] shift_r;
	reg [2:0]  trig_sync_r;
	reg [15:0] sel_s1_r;
	reg [15:0] sel_s2_r;
	reg [15:0] sel_cap_r;
	reg [1:0]  sda_sync_r;

	wire       tick;
	wire       trig_rise;
	wire       ack_bit;
	wire [15:0] sel_pins;

	assign tick      = (tick_cnt_r == QTR_LAST);
	assign trig_rise = trig_sync_r[1] & ~trig_sync_r[2];
	assign ack_bit   = (bit_idx_r == 5'd8) || (bit_idx_r == 5'd17) || (bit_idx_r == 5'd26);
	assign sel_pins  = {i_mem_freq_select, i_chan_freq_select_d, i_chan_freq_select_c,
	                    i_chan_freq_select_b, i_chan_freq_select_a};

	//--------------------------------------------------------------
	// Frequency code for a four-channel select
	//--------------------------------------------------------------
	function [7:0] qsfp_code;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: qsfp_code = 8'h00;                  // Powered down
				3'h1: qsfp_code = 8'h81;                  // 644.53125 MHz
				3'h2: qsfp_code = 8'h82;                  // 322.26 MHz
				3'h3: qsfp_code = 8'h83;                  // 312.25 MHz
				3'h4: qsfp_code = 8'h84;                  // 250 MHz
				3'h5: qsfp_code = 8'h85;                  // 156.25 MHz
				3'h6: qsfp_code = 8'h86;                  // 125 MHz
				default: qsfp_code = 8'h87;               // 100 MHz
			endcase
		end
	endfunction

	//--------------------------------------------------------------
	// Frequency code for the memory clock select
	//--------------------------------------------------------------
	function [7:0] mem_code;
		input [3:0] sel;
		begin
			case (sel)
				4'h0: mem_code = 8'h90;                   // 275 MHz
				4'h1: mem_code = 8'h91;                   // 250 MHz
				4'h2: mem_code = 8'h92;                   // 225 MHz
				default: mem_code = 8'h90;                // Unlisted codes fall back to 275 MHz
			endcase
		end
	endfunction

	//--------------------------------------------------------------
	// Frame for one table entry: address, register, value, each + ack slot
	//--------------------------------------------------------------
	function [26:0] frame;
		input [2:0]  ent;
		input [15:0] sel;
		reg   [7:0]  ra;
		reg   [7:0]  val;
		begin
			ra  = `CSC_REG_APPLY;
			val = `CSC_APPLY_VAL;
			if (ent != LAST_ENT) begin
				ra = `CSC_REG_OUT_BASE + {5'h00, ent};
				if (MEM_VARIANT != 0)
					val = mem_code(sel[15:12]);
				else
					val = qsfp_code(sel[ent*3 +: 3]);
			end
			frame = {`CSC_DEV_ADDR, 1'b1, ra, 1'b1, val, 1'b1};
		end
	endfunction

	//--------------------------------------------------------------
	// Pin synchronisers
	//--------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			// Ones, so that a start held high through reset is not an edge
			trig_sync_r <= 3'h7;
			sel_s1_r    <= `CSC_SEL_RST;
			sel_s2_r    <= `CSC_SEL_RST;
			sda_sync_r  <= 2'h3;
		end else begin
			trig_sync_r <= {trig_sync_r[1:0], i_config_trigger};
			sel_s1_r    <= sel_pins;
			sel_s2_r    <= sel_s1_r;
			sda_sync_r  <= {sda_sync_r[0], i_sda};
		end
	end

	//--------------------------------------------------------------
	// Sequencer and bit engine
	//--------------------------------------------------------------
	always @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			state_r                <= ST_IDLE;
			tick_cnt_r             <= 7'h00;
			phase_r                <= 2'h0;
			bit_idx_r              <= 5'h00;
			entry_r                <= 3'h0;
			shift_r                <= 27'h0000000;
			sel_cap_r              <= `CSC_SEL_RST;
			o_sda                  <= 1'b0;
			o_sda_oe               <= 1'b0;
			o_scl                  <= 1'b1;
			o_config_complete_flag <= 1'b0;
			o_nack_err             <= 1'b0;
		end else begin
			o_sda <= 1'b0;
			if (state_r == ST_IDLE || tick)
				tick_cnt_r <= 7'h00;
			else
				tick_cnt_r <= tick_cnt_r + 7'h01;
			case (state_r)
				ST_IDLE: begin
					o_scl    <= 1'b1;
					o_sda_oe <= 1'b0;
					phase_r  <= 2'h0;
					if (trig_rise) begin
						state_r                <= ST_START;
						entry_r                <= 3'h0;
						sel_cap_r              <= sel_s2_r;
						o_nack_err             <= 1'b0;
						o_config_complete_flag <= 1'b0;
					end
				end
				ST_START: begin
					if (tick) begin
						phase_r  <= phase_r + 2'h1;
						o_scl    <= (phase_r < 2'h2);
						o_sda_oe <= (phase_r >= 2'h1);
						if (phase_r == 2'h3) begin
							state_r   <= ST_BIT;
							bit_idx_r <= 5'h00;
							shift_r   <= frame(entry_r, sel_cap_r);
						end
					end
				end
				ST_BIT: begin
					if (tick) begin
						phase_r <= phase_r + 2'h1;
						case (phase_r)
							2'h0: begin
								// Data changes only while the serial clock is low
								o_sda_oe <= ~shift_r[26];
							end
							2'h1: begin
								o_scl <= 1'b1;
							end
							2'h2: begin
								if (ack_bit && sda_sync_r[1])
									o_nack_err <= 1'b1;
							end
							default: begin
								o_scl     <= 1'b0;
								shift_r   <= {shift_r[25:0], 1'b1};
								bit_idx_r <= bit_idx_r + 5'h01;
								if (bit_idx_r == `CSC_LAST_BIT)
									state_r <= ST_STOP;
							end
						endcase
					end
				end
				ST_STOP: begin
					if (tick) begin
						phase_r  <= phase_r + 2'h1;
						o_scl    <= (phase_r != 2'h0);
						o_sda_oe <= (phase_r < 2'h2);
						if (phase_r == 2'h3) begin
							if (entry_r == LAST_ENT) begin
								state_r                <= ST_IDLE;
								o_config_complete_flag <= 1'b1;
							end else begin
								entry_r <= entry_r + 3'h1;
								state_r <= ST_START;
							end
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// *** hdl/csc_defines.vh ***
// Constants for the clock synthesizer configuration controller
//--------------------------------------------------------------
// Functional notes
// - Reset is synchronous, active low.
// - Configuration starts only on start rising edge.
// - Done flag low during pass, high after.
// - Master drives clock; data line bidirectional.
// - Four-channel 3-bit select frequency map.
// - Memory variant 4-bit select frequency map.
// - New start edge reprograms changed selects; edges during a pass are ignored.
// - Synthesizer addressed with byte 0xEE.
// - Four channels feed transceiver ports A-D.
// - One select drives six memory clocks.
//--------------------------------------------------------------
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH

`define CSC_SYS_CLK_MHZ   50
`define CSC_I2C_QTR_NS    2500
`define CSC_I2C_QTR_CYC   ((`CSC_I2C_QTR_NS * `CSC_SYS_CLK_MHZ) / 1000)
`define CSC_DEV_ADDR      8'hEE
`define CSC_REG_OUT_BASE  8'h10
`define CSC_REG_APPLY     8'h1C
`define CSC_APPLY_VAL     8'h01
`define CSC_OUT_EN_BIT    7
`define CSC_FRAME_BITS    27
`define CSC_LAST_BIT      5'd26
`define CSC_ENTRIES_QSFP  3'd4
`define CSC_ENTRIES_MEM   3'd6
`define CSC_SEL_RST       16'h0000

`endif
